// ### src/irq_mask_gate.sv
// Interrupt enable mask with set and clear views, and the gated external interrupt line.
// Assumes the event register sits on the same clock and drives eventBits directly.
`timescale 1ns/1ns
`include "irq_mask_gate_consts.svh"

module irq_mask_gate #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] eventBits,
    output logic irqOut
);

    img_pkg::img_word_t mask_q; // Enable mask, reserved bits held at zero
    img_pkg::img_word_t mask_d; // Next mask value
    img_pkg::img_word_t prdata_q; // Registered read answer
    img_pkg::img_target_t target; // Addressed view of the mask
    logic accessOpen; // First access cycle
    logic accessDone; // Completing access cycle
    logic [30:0] armed; // Event AND enable, per source

    // Bus timing and decode
    img_apb_port #(
        .ADDR_W(ADDR_W)
    ) u_port (
        .ref_clk(ref_clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .paddr(paddr),
        .pready(pready),
        .pslverr(pslverr),
        .target(target),
        .accessOpen(accessOpen),
        .accessDone(accessDone)
    );

    // Next mask: ones set or clear, zeros leave bits alone
    always_comb begin
        mask_d = mask_q;
        if (accessDone && pwrite) begin
            unique case (target)
                img_pkg::IMG_TGT_SET: begin
                    mask_d = mask_q | (pwdata & `IMG_MASK_RW);
                end
                img_pkg::IMG_TGT_CLR: begin
                    mask_d = mask_q & ~(pwdata & `IMG_MASK_RW);
                end
                img_pkg::IMG_TGT_NONE: begin
                    // Unmapped writes are dropped; the error flag tells software
                    mask_d = mask_q;
                end
            endcase
        end
    end

    // Mask storage; reset clears every enable so nothing fires before software opts in
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mask_q <= `IMG_MASK_RST;
        end else begin
            mask_q <= mask_d;
        end
    end

    // Read answer, captured on the same edge that raises pready
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (accessOpen) begin
            if (target != img_pkg::IMG_TGT_NONE) begin
                // Both views return the same mask contents
                prdata_q <= mask_q & `IMG_MASK_RW;
            end else begin
                // Unmapped reads return zero alongside the error
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    assign prdata = prdata_q;

    // Per-source arming, same bit position in event and mask
    // Maker-defined source; the one bit whose event meaning is not shared
    assign armed[`IMG_B_MAKER_DEFINED_IRQ] =
        eventBits[`IMG_B_MAKER_DEFINED_IRQ] & mask_q[`IMG_B_MAKER_DEFINED_IRQ];

    // Software-raised source, lets a driver exercise its own handler
    assign armed[`IMG_B_SOFTWARE_RAISED_IRQ] =
        eventBits[`IMG_B_SOFTWARE_RAISED_IRQ] & mask_q[`IMG_B_SOFTWARE_RAISED_IRQ];

    // Reserved position tied to zero, so it never arms whatever event and mask hold
    assign armed[`IMG_B_RSVD_HI] = 1'b0;

    // Late acknowledge
    assign armed[`IMG_B_LATE_ACK] =
        eventBits[`IMG_B_LATE_ACK] & mask_q[`IMG_B_LATE_ACK];

    // Physical layer register readback
    assign armed[`IMG_B_PHY_READBACK_ARRIVED] =
        eventBits[`IMG_B_PHY_READBACK_ARRIVED] & mask_q[`IMG_B_PHY_READBACK_ARRIVED];

    // Cycle that overran its slot
    assign armed[`IMG_B_OVERLONG_CYCLE] =
        eventBits[`IMG_B_OVERLONG_CYCLE] & mask_q[`IMG_B_OVERLONG_CYCLE];

    // Fatal fault; masking it hides a stalled controller
    assign armed[`IMG_B_FATAL_FAULT] =
        eventBits[`IMG_B_FATAL_FAULT] & mask_q[`IMG_B_FATAL_FAULT];

    // Cycle timer mismatch and missed cycle start
    assign armed[`IMG_B_CYCLE_TIMER_MISMATCH] =
        eventBits[`IMG_B_CYCLE_TIMER_MISMATCH] & mask_q[`IMG_B_CYCLE_TIMER_MISMATCH];
    assign armed[`IMG_B_MISSED_CYCLE_START] =
        eventBits[`IMG_B_MISSED_CYCLE_START] & mask_q[`IMG_B_MISSED_CYCLE_START];

    // Seconds rollover and new isochronous cycle
    assign armed[`IMG_B_SECONDS_ROLLOVER] =
        eventBits[`IMG_B_SECONDS_ROLLOVER] & mask_q[`IMG_B_SECONDS_ROLLOVER];
    assign armed[`IMG_B_NEW_ISO_CYCLE] =
        eventBits[`IMG_B_NEW_ISO_CYCLE] & mask_q[`IMG_B_NEW_ISO_CYCLE];

    // Physical layer status transfer
    assign armed[`IMG_B_PHY_STATUS_XFER] =
        eventBits[`IMG_B_PHY_STATUS_XFER] & mask_q[`IMG_B_PHY_STATUS_XFER];

    // Physical layer access that failed
    assign armed[`IMG_B_PHY_ACCESS_FAILED] =
        eventBits[`IMG_B_PHY_ACCESS_FAILED] & mask_q[`IMG_B_PHY_ACCESS_FAILED];

    // Bus reinit and both node identification sources
    assign armed[`IMG_B_SERIAL_BUS_REINIT] =
        eventBits[`IMG_B_SERIAL_BUS_REINIT] & mask_q[`IMG_B_SERIAL_BUS_REINIT];
    assign armed[`IMG_B_NODE_IDENT_DONE] =
        eventBits[`IMG_B_NODE_IDENT_DONE] & mask_q[`IMG_B_NODE_IDENT_DONE];
    assign armed[`IMG_B_NODE_IDENT_DONE_STICKY] =
        eventBits[`IMG_B_NODE_IDENT_DONE_STICKY] & mask_q[`IMG_B_NODE_IDENT_DONE_STICKY];

    // Reserved gap between the two fields
    assign armed[14:10] = 5'h00;

    // Atomic reply and buffered write faults
    assign armed[`IMG_B_ATOMIC_REPLY_FAULT] =
        eventBits[`IMG_B_ATOMIC_REPLY_FAULT] & mask_q[`IMG_B_ATOMIC_REPLY_FAULT];
    assign armed[`IMG_B_BUFFERED_WRITE_FAULT] =
        eventBits[`IMG_B_BUFFERED_WRITE_FAULT] & mask_q[`IMG_B_BUFFERED_WRITE_FAULT];

    // Iso DMA events are level ORs from the context registers, not latched here
    assign armed[`IMG_B_ISO_RECEIVE_DMA] =
        eventBits[`IMG_B_ISO_RECEIVE_DMA] & mask_q[`IMG_B_ISO_RECEIVE_DMA];
    assign armed[`IMG_B_ISO_TRANSMIT_DMA] =
        eventBits[`IMG_B_ISO_TRANSMIT_DMA] & mask_q[`IMG_B_ISO_TRANSMIT_DMA];

    // Packet arrivals in the receive buffers
    assign armed[`IMG_B_RESPONSE_PKT_ARRIVED] =
        eventBits[`IMG_B_RESPONSE_PKT_ARRIVED] & mask_q[`IMG_B_RESPONSE_PKT_ARRIVED];
    assign armed[`IMG_B_REQUEST_PKT_ARRIVED] =
        eventBits[`IMG_B_REQUEST_PKT_ARRIVED] & mask_q[`IMG_B_REQUEST_PKT_ARRIVED];

    // Asynchronous receive DMA completions
    assign armed[`IMG_B_ASYNC_RX_RESPONSE_DMA] =
        eventBits[`IMG_B_ASYNC_RX_RESPONSE_DMA] & mask_q[`IMG_B_ASYNC_RX_RESPONSE_DMA];
    assign armed[`IMG_B_ASYNC_RX_REQUEST_DMA] =
        eventBits[`IMG_B_ASYNC_RX_REQUEST_DMA] & mask_q[`IMG_B_ASYNC_RX_REQUEST_DMA];

    // Asynchronous send completions
    assign armed[`IMG_B_RESPONSE_SEND_DONE] =
        eventBits[`IMG_B_RESPONSE_SEND_DONE] & mask_q[`IMG_B_RESPONSE_SEND_DONE];
    assign armed[`IMG_B_REQUEST_SEND_DONE] =
        eventBits[`IMG_B_REQUEST_SEND_DONE] & mask_q[`IMG_B_REQUEST_SEND_DONE];

    // Gate and combine; bit 31 of the event input is not a source and is ignored
    img_irq_gate #(
        .SRC_W(31)
    ) u_gate (
        .ref_clk(ref_clk),
        .rst(rst),
        .gateOn(mask_q[`IMG_B_GLOBAL_IRQ_GATE]),
        .armed(armed),
        .irqOut(irqOut)
    );

    // Checks on the mask, the bus answer and the interrupt line
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Raw armed set as software would compute it, independent of the per-field wiring
    logic anyArmed;
    assign anyArmed = |(eventBits & mask_q & `IMG_EVENT_SRC);

    // Gate bit and raw event AND enable, bypassing the per-field arming wires
    logic gateOpen;
    img_pkg::img_word_t rawArmed;
    assign gateOpen = mask_q[`IMG_B_GLOBAL_IRQ_GATE];
    assign rawArmed = eventBits & mask_q;

    a_gate_closed: assert property (!mask_q[31] |=> !irqOut)
        else $error("interrupt raised with global gate off");

    a_irq_raise: assert property ((mask_q[31] && anyArmed) |=> irqOut)
        else $error("interrupt missing with gate on and armed source");

    a_irq_idle: assert property ((mask_q[31] && !anyArmed) |=> !irqOut)
        else $error("interrupt raised with no armed source");

    a_maker_bit: assert property ((mask_q[31] && eventBits[30] && !mask_q[30]
        && ((eventBits & mask_q & 32'h3FFF_FFFF) == 32'h0000_0000)) |=> !irqOut)
        else $error("maker-defined event raised interrupt while disabled");

    a_soft_bit: assert property ((mask_q[31] && eventBits[29] && mask_q[29]) |=> irqOut)
        else $error("software-raised interrupt not delivered");

    a_rsvd_zero: assert property ((mask_q & ~`IMG_MASK_RW) == 32'h0000_0000)
        else $error("reserved mask bits not zero");

    a_read_rsvd: assert property (pready |-> (prdata[28] == 1'b0 && prdata[14:10] == 5'h00))
        else $error("reserved bits read back nonzero");

    a_read_mask: assert property ((pready && !pwrite && !pslverr) |-> prdata == mask_q)
        else $error("read data differs from mask contents");

    a_set_write: assert property ((accessDone && pwrite && target == img_pkg::IMG_TGT_SET)
        |=> mask_q == ($past(mask_q) | ($past(pwdata) & `IMG_MASK_RW)))
        else $error("set view did not set written ones");

    a_clr_write: assert property ((accessDone && pwrite && target == img_pkg::IMG_TGT_CLR)
        |=> mask_q == ($past(mask_q) & ~($past(pwdata) & `IMG_MASK_RW)))
        else $error("clear view did not clear written ones");

    a_mask_steady: assert property (!(accessDone && pwrite) |=> $stable(mask_q))
        else $error("mask changed without a write");

    a_one_wait: assert property ((psel && penable && !pready) |=> pready ##1 !pready)
        else $error("answer not given after one wait state");

    a_unmapped: assert property ((pready && target == img_pkg::IMG_TGT_NONE) |-> pslverr)
        else $error("unmapped access answered without error");

    // Sources 27 down to 0, alone or in groups of two or three, so a crossed arming wire shows by group name
    a_late_ack: assert property ((gateOpen && rawArmed[`IMG_B_LATE_ACK]) |=> irqOut)
        else $error("late acknowledge interrupt not delivered");

    a_phy_readback: assert property ((gateOpen && rawArmed[`IMG_B_PHY_READBACK_ARRIVED]) |=> irqOut)
        else $error("physical layer readback interrupt not delivered");

    a_overlong_cycle: assert property ((gateOpen && rawArmed[`IMG_B_OVERLONG_CYCLE]) |=> irqOut)
        else $error("overlong cycle interrupt not delivered");

    a_fatal_fault: assert property ((gateOpen && rawArmed[`IMG_B_FATAL_FAULT]) |=> irqOut)
        else $error("fatal fault interrupt not delivered");

    a_cycle_pair: assert property (
        (gateOpen && |rawArmed[`IMG_B_CYCLE_TIMER_MISMATCH:`IMG_B_MISSED_CYCLE_START]) |=> irqOut)
        else $error("cycle timer or missed cycle interrupt not delivered");

    a_time_pair: assert property (
        (gateOpen && |rawArmed[`IMG_B_SECONDS_ROLLOVER:`IMG_B_NEW_ISO_CYCLE]) |=> irqOut)
        else $error("rollover or new cycle interrupt not delivered");

    a_phy_status: assert property ((gateOpen && rawArmed[`IMG_B_PHY_STATUS_XFER]) |=> irqOut)
        else $error("status transfer interrupt not delivered");

    a_phy_access: assert property ((gateOpen && rawArmed[`IMG_B_PHY_ACCESS_FAILED]) |=> irqOut)
        else $error("access failed interrupt not delivered");

    a_reinit_trio: assert property (
        (gateOpen && |rawArmed[`IMG_B_SERIAL_BUS_REINIT:`IMG_B_NODE_IDENT_DONE_STICKY]) |=> irqOut)
        else $error("reinit or node ident interrupt not delivered");

    a_fault_pair: assert property (
        (gateOpen && |rawArmed[`IMG_B_ATOMIC_REPLY_FAULT:`IMG_B_BUFFERED_WRITE_FAULT]) |=> irqOut)
        else $error("atomic or buffered write fault interrupt not delivered");

    a_iso_pair: assert property (
        (gateOpen && |rawArmed[`IMG_B_ISO_RECEIVE_DMA:`IMG_B_ISO_TRANSMIT_DMA]) |=> irqOut)
        else $error("iso DMA interrupt not delivered");

    a_pkt_pair: assert property (
        (gateOpen && |rawArmed[`IMG_B_RESPONSE_PKT_ARRIVED:`IMG_B_REQUEST_PKT_ARRIVED]) |=> irqOut)
        else $error("packet arrival interrupt not delivered");

    a_rx_dma_pair: assert property (
        (gateOpen && |rawArmed[`IMG_B_ASYNC_RX_RESPONSE_DMA:`IMG_B_ASYNC_RX_REQUEST_DMA]) |=> irqOut)
        else $error("receive DMA interrupt not delivered");

    a_send_pair: assert property (
        (gateOpen && |rawArmed[`IMG_B_RESPONSE_SEND_DONE:`IMG_B_REQUEST_SEND_DONE]) |=> irqOut)
        else $error("send done interrupt not delivered");

    // Bus answer details: error only with ready, unmapped writes dropped, read data held
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error answer outside a completing cycle");

    a_unmapped_drop: assert property ((accessDone && pwrite && target == img_pkg::IMG_TGT_NONE)
        |=> $stable(mask_q))
        else $error("unmapped write changed the mask");

    a_unmapped_zero: assert property ((pready && pslverr) |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    a_rdata_hold: assert property (!accessOpen |=> $stable(prdata))
        else $error("read data moved outside a capture");

    // Main scenarios
    c_set_write: cover property (accessDone && pwrite && target == img_pkg::IMG_TGT_SET);
    c_clr_write: cover property (accessDone && pwrite && target == img_pkg::IMG_TGT_CLR);
    c_irq_rise: cover property (!irqOut ##1 irqOut);
    c_unmapped: cover property (pready && pslverr);
    c_gate_blocked: cover property (!gateOpen && |(rawArmed & `IMG_EVENT_SRC));

endmodule : irq_mask_gate

// ### src/irq_mask_gate_consts.svh
// Register offsets, field positions and reset values of the interrupt enable mask.
// Assumes a byte-addressed register bus with 32-bit aligned words.
`ifndef IRQ_MASK_GATE_CONSTS_SVH
`define IRQ_MASK_GATE_CONSTS_SVH

// Byte offsets of the two views of the enable mask
`define IMG_OFS_SET 8'h88
`define IMG_OFS_CLR 8'h8C

// Bits that software may set and clear; 28 and 14..10 are read-only zero
`define IMG_MASK_RW 32'hEFFF_83FF
// Reset value of the whole mask
`define IMG_MASK_RST 32'h0000_0000
// Event bits taken as sources (all but the gate position); 28 and 14..10 never raise the output
`define IMG_EVENT_SRC 32'h7FFF_FFFF

// Field positions
`define IMG_B_GLOBAL_IRQ_GATE 31
`define IMG_B_MAKER_DEFINED_IRQ 30
`define IMG_B_SOFTWARE_RAISED_IRQ 29
`define IMG_B_RSVD_HI 28
`define IMG_B_LATE_ACK 27
`define IMG_B_PHY_READBACK_ARRIVED 26
`define IMG_B_OVERLONG_CYCLE 25
`define IMG_B_FATAL_FAULT 24
`define IMG_B_CYCLE_TIMER_MISMATCH 23
`define IMG_B_MISSED_CYCLE_START 22
`define IMG_B_SECONDS_ROLLOVER 21
`define IMG_B_NEW_ISO_CYCLE 20
`define IMG_B_PHY_STATUS_XFER 19
`define IMG_B_PHY_ACCESS_FAILED 18
`define IMG_B_SERIAL_BUS_REINIT 17
`define IMG_B_NODE_IDENT_DONE 16
`define IMG_B_NODE_IDENT_DONE_STICKY 15
`define IMG_B_ATOMIC_REPLY_FAULT 9
`define IMG_B_BUFFERED_WRITE_FAULT 8
`define IMG_B_ISO_RECEIVE_DMA 7
`define IMG_B_ISO_TRANSMIT_DMA 6
`define IMG_B_RESPONSE_PKT_ARRIVED 5
`define IMG_B_REQUEST_PKT_ARRIVED 4
`define IMG_B_ASYNC_RX_RESPONSE_DMA 3
`define IMG_B_ASYNC_RX_REQUEST_DMA 2
`define IMG_B_RESPONSE_SEND_DONE 1
`define IMG_B_REQUEST_SEND_DONE 0

`endif

// ### src/img_pkg.sv
// Types shared by the interrupt enable mask block.
// Assumes the constants header is included by each design file that needs numbers.
package img_pkg;

    // One register word
    typedef logic [31:0] img_word_t;

    // Which view of the mask an access addresses
    typedef enum logic [1:0] {
        IMG_TGT_NONE,
        IMG_TGT_SET,
        IMG_TGT_CLR
    } img_target_t;

endpackage : img_pkg

// ### src/img_apb_port.sv
// APB slave timing for the mask block: decode, one wait state, error on unmapped address.
// Assumes an APB master that holds its request until pready is seen high.
`timescale 1ns/1ns
`include "irq_mask_gate_consts.svh"

module img_apb_port #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_W-1:0] paddr,
    output logic pready,
    output logic pslverr,
    output img_pkg::img_target_t target,
    output logic accessOpen,
    output logic accessDone
);

    logic readyQ; // Completion flag, high for exactly one access cycle
    logic errQ; // Error answer, valid with readyQ

    // Address decode of the two mapped words
    always_comb begin
        if (paddr == ADDR_W'(`IMG_OFS_SET)) begin
            target = img_pkg::IMG_TGT_SET;
        end else if (paddr == ADDR_W'(`IMG_OFS_CLR)) begin
            target = img_pkg::IMG_TGT_CLR;
        end else begin
            target = img_pkg::IMG_TGT_NONE;
        end
    end

    // First access cycle, before the answer is given
    assign accessOpen = psel && penable && !readyQ;
    // Edge at which the transfer completes and a write takes effect
    assign accessDone = psel && penable && readyQ;

    // One wait state keeps read data coming from a flop
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            readyQ <= 1'b0;
            errQ <= 1'b0;
        end else begin
            readyQ <= accessOpen;
            errQ <= accessOpen && (target == img_pkg::IMG_TGT_NONE);
        end
    end

    assign pready = readyQ;
    assign pslverr = errQ;

endmodule : img_apb_port

// ### src/img_irq_gate.sv
// Combines armed event bits under the global gate into one registered interrupt line.
// Assumes armed bits are already event AND enable, on the same clock.
`timescale 1ns/1ns

module img_irq_gate #(
    parameter int SRC_W = 31
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic gateOn,
    input wire logic [SRC_W-1:0] armed,
    output logic irqOut
);

    logic irqQ; // Registered so the pin never glitches

    // Gate closed means silence whatever the sources say
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irqQ <= 1'b0;
        end else begin
            irqQ <= gateOn && (|armed);
        end
    end

    assign irqOut = irqQ;

endmodule : img_irq_gate

// ### testbench/img_event_model.sv
// Stand-in for the interrupt event register that sits beside the mask block.
// Assumes the bench loads new contents with a one-cycle strobe on the same clock.
`timescale 1ns/1ns

module img_event_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic evLoad,
    input wire logic [31:0] evValue,
    output logic [31:0] eventBits
);
    logic [30:0] evQ; // Latched event sources
    logic toggleQ; // Gate position carries no event, so it flips every cycle

    // Load on strobe; junk on bit 31 must never reach the interrupt line
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            evQ <= 31'h0000_0000;
            toggleQ <= 1'b0;
        end else begin
            toggleQ <= ~toggleQ;
            if (evLoad) begin
                evQ <= evValue[30:0];
            end
        end
    end

    assign eventBits = {toggleQ, evQ};
endmodule : img_event_model

// ### testbench/irq_mask_gate_tb.sv
// Self-checking bench for the interrupt enable mask: APB views, reserved bits, gating.
// Assumes the design answers APB with one wait state and registers irqOut one cycle late.
`timescale 1ns/1ns
`include "irq_mask_gate_consts.svh"

module irq_mask_gate_tb;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, irqOut, evLoad, errB;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, eventBits, evValue, rdW;
    int n_fail = 0, checked = 0, cycles = 0;

    irq_mask_gate #(.ADDR_W(8)) dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .eventBits(eventBits), .irqOut(irqOut));

    img_event_model evm (.ref_clk(ref_clk), .rst(rst), .evLoad(evLoad), .evValue(evValue),
        .eventBits(eventBits));

    // Free-running 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Hang guard: the whole run needs well under 3000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // No cycle count assumed: the wait ends on pready, and only the hang guard ends it otherwise
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdW = prdata;
        errB = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Load event sources, then give the partner and irqOut their register stages
    task automatic load_events(input logic [31:0] v);
        @(posedge ref_clk);
        evLoad <= 1'b1;
        evValue <= v;
        @(posedge ref_clk);
        evLoad <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : load_events

    task automatic test_reset();
        apb(1'b0, `IMG_OFS_SET, 32'h0000_0000);
        chk_word(rdW, 32'h0000_0000);
        chk_bit(irqOut, 1'b0);
    endtask : test_reset

    // Both views read the same mask; ones set or clear, zeros leave bits alone
    task automatic test_views();
        apb(1'b1, `IMG_OFS_SET, 32'hFFFF_FFFF);
        apb(1'b0, `IMG_OFS_SET, 32'h0000_0000);
        chk_word(rdW, 32'hEFFF_83FF);
        chk_bit(errB, 1'b0);
        apb(1'b1, `IMG_OFS_CLR, 32'h0000_0001);
        apb(1'b0, `IMG_OFS_CLR, 32'h0000_0000);
        chk_word(rdW, 32'hEFFF_83FE);
        apb(1'b1, `IMG_OFS_SET, 32'h0000_0000);
        apb(1'b1, `IMG_OFS_CLR, 32'h8000_0000);
        apb(1'b0, `IMG_OFS_SET, 32'h0000_0000);
        chk_word(rdW, 32'h6FFF_83FE);
    endtask : test_views

    // Reserved positions never arm the line even with every enable written
    task automatic test_reserved();
        apb(1'b1, `IMG_OFS_SET, 32'hFFFF_FFFF);
        load_events(32'h1000_0000);
        chk_bit(irqOut, 1'b0);
        load_events(32'h0000_7C00);
        chk_bit(irqOut, 1'b0);
        load_events(32'h0000_0001);
        chk_bit(irqOut, 1'b1);
        apb(1'b1, `IMG_OFS_CLR, 32'h8000_0000);
        repeat (2) @(posedge ref_clk);
        chk_bit(irqOut, 1'b0);
    endtask : test_reserved

    // Unmapped place: error flagged, read gives zero, write lands nowhere
    task automatic test_unmapped();
        apb(1'b0, 8'h80, 32'h0000_0000);
        chk_word(rdW, 32'h0000_0000);
        chk_bit(errB, 1'b1);
        apb(1'b1, `IMG_OFS_CLR, 32'hFFFF_FFFF);
        apb(1'b1, 8'h90, 32'hFFFF_FFFF);
        chk_bit(errB, 1'b1);
        apb(1'b0, `IMG_OFS_CLR, 32'h0000_0000);
        chk_word(rdW, 32'h0000_0000);
    endtask : test_unmapped

    // Reset in mid-run drops every enable and the line at once
    task automatic test_midreset();
        apb(1'b1, `IMG_OFS_SET, 32'hFFFF_FFFF);
        load_events(32'h0000_0001);
        chk_bit(irqOut, 1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk_bit(irqOut, 1'b0);
        rst <= 1'b0;
        apb(1'b0, `IMG_OFS_CLR, 32'h0000_0000);
        chk_word(rdW, 32'h0000_0000);
        chk_bit(irqOut, 1'b0);
    endtask : test_midreset

    // Each source alone: gate closed, then needs its own event, then fires
    // and
    task automatic test_sources();
        logic [31:0] b;
        for (int n = 0; n < 31; n++) begin
            b = 32'h0000_0001 << n;
            if ((`IMG_MASK_RW & b) != 32'h0000_0000) begin
                apb(1'b1, `IMG_OFS_CLR, 32'hFFFF_FFFF);
                apb(1'b1, `IMG_OFS_SET, b);
                load_events(32'h7FFF_FFFF);
                chk_bit(irqOut, 1'b0);
                apb(1'b1, `IMG_OFS_SET, 32'h8000_0000);
                repeat (2) @(posedge ref_clk);
                chk_bit(irqOut, 1'b1);
                load_events(32'h7FFF_FFFF & ~b);
                chk_bit(irqOut, 1'b0);
                load_events(b);
                chk_bit(irqOut, 1'b1);
            end
        end
    endtask : test_sources

    // Main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        evLoad = 1'b0;
        evValue = 32'h0000_0000;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        test_reset();
        test_views();
        test_reserved();
        test_unmapped();
        test_midreset();
        test_sources();
        wrap_up();
    end
endmodule : irq_mask_gate_tb
